// ===== logic/bmec_pkg.sv
/*
  constants used by the pattern engine control block; its buffer uses none.
  assumes an 8-bit host port with a 4-bit address and 8-bit pattern words.
*/
`default_nettype none
package bmec_pkg;
  // host port map
  localparam logic [3:0] ADDR_WIDTH_INV_ERR = 4'h1;
  localparam logic [3:0] ADDR_END_ADDR_LOW = 4'h2;
  localparam logic [3:0] ADDR_ACCESS_BANK_CLK = 4'h3;
  localparam logic [7:0] RESET_CTRL = 8'h00;
  // width_invert_error_ctrl fields
  localparam int WIDTH_SEL_HI = 7;
  localparam int WIDTH_SEL_LO = 6;
  localparam int TX_DATA_FLIP = 5;
  localparam int RX_DATA_FLIP = 4;
  localparam int SINGLE_ERROR_TRIGGER = 3;
  localparam int ERR_RATE_SEL2 = 2;
  localparam int ERR_RATE_SEL0 = 0;
  // access_bank_clock_ctrl fields
  localparam int TXCLK_OUT_POLARITY = 5;
  localparam int MEM_DIR_READ = 4;
  localparam int MEM_HOST_OWN = 3;
  localparam int COUNT_BANK = 2;
  localparam int SEED_BANK = 1;
  localparam int PAT_END_BIT_TOP = 0;
  typedef enum logic [1:0] {
    BMEC_W_BIT = 2'b00,
    BMEC_W_NIBBLE = 2'b01,
    BMEC_W_BYTE = 2'b10,
    BMEC_W_INVALID = 2'b11
  } bmec_width_t;
  localparam logic [2:0] RATE_NONE = 3'h0;
  localparam logic [2:0] RATE_E1 = 3'h1;
  localparam logic [2:0] RATE_E2 = 3'h2;
  localparam logic [23:0] PER_E1 = 24'h00000a;
  localparam logic [23:0] PER_E2 = 24'h000064;
  localparam logic [23:0] PER_E3 = 24'h0003e8;
  localparam logic [23:0] PER_E4 = 24'h002710;
  localparam logic [23:0] PER_E5 = 24'h0186a0;
  localparam logic [23:0] PER_E6 = 24'h0f4240;
  localparam logic [23:0] PER_E7 = 24'h989680;
  localparam logic [23:0] PER_OCT1 = 24'h000008;
  localparam logic [23:0] PER_OCT2 = 24'h000040;
  localparam logic [7:0] MASK_BIT = 8'h01;
  localparam logic [7:0] MASK_NIBBLE = 8'h0f;
  localparam logic [7:0] MASK_BYTE = 8'hff;
  localparam logic [3:0] BITS_BIT = 4'h1;
  localparam logic [3:0] BITS_NIBBLE = 4'h4;
  localparam logic [3:0] BITS_BYTE = 4'h8;
endpackage
`default_nettype wire

// ===== logic/bmec_stream_if.sv
/*
  valid/ready word stream between the control block and its buffer.
  assumes both ends run on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
interface bmec_stream_if #(parameter int W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ===== logic/bmec_fifo.sv
/*
  word buffer with a registered head word; holds DEPTH words in the array
  plus one in the output register. assumes one clock and async reset.
*/
`timescale 1ns/1ns
`default_nettype none
module bmec_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // streams
  bmec_stream_if.snk wr_if,
  bmec_stream_if.src rd_if
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("bmec_fifo: DEPTH must be a power of two of at least 2");
  end
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic [W-1:0] head;
    logic head_ok;
  } bmec_fifo_state_t;
  bmec_fifo_state_t st_r, st_nxt;
  logic push, pop, load;
  assign wr_if.ready = (st_r.cnt != (AW+1)'(DEPTH));
  assign rd_if.valid = st_r.head_ok;
  assign rd_if.data = st_r.head;
  always_comb begin
    st_nxt = st_r;
    push = wr_if.valid && wr_if.ready;
    pop = st_r.head_ok && rd_if.ready;
    load = (st_r.cnt != '0) && (!st_r.head_ok || pop);
    if (push) begin
      st_nxt.mem[st_r.wp] = wr_if.data;
      st_nxt.wp = st_r.wp + 1'b1;
    end
    if (load) begin
      st_nxt.head = st_r.mem[st_r.rp];
      st_nxt.rp = st_r.rp + 1'b1;
      st_nxt.head_ok = 1'b1;
    end else if (pop) begin
      st_nxt.head_ok = 1'b0;
    end
    st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(load);
  end
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  a_fifo_no_overrun: assert property (st_r.cnt <= (AW+1)'(DEPTH))
    else $error("fifo count above depth");
  c_fifo_full: cover property (!wr_if.ready);
endmodule // bmec_fifo
`default_nettype wire

// ===== logic/bmec_ctrl.sv
/*
  control registers of a bit-error-rate pattern engine: width, inversion,
  error insertion, pattern end address, memory access and bank steering,
  gapped transmit clock. assumes the host port, tx/rx clocks and rx data
  are asynchronous pins; pattern words arrive on the core clock.
*/
// Overview of operation
// - width code: 00 bit, 01 nibble, 10 byte
// - tx flip set inverts every outbound bit
// - rx flip set inverts inbound bits before checking
// - trigger rising edge inverts one following bit
// - zero-suppress pattern delays that error one clock
// - rate code 0 none, else one per decade
// - nibble/byte with rate 1 gives one per eight
// - byte with rate 2 gives one per sixty-four
// - nine-bit end address from two registers
// - polarity bit inverts the gapped clock output
// - memory select: 0 state machine, 1 host
// - direction bit: 0 host writes, 1 reads
// - count bank bit steers addresses Ah-Fh
// - seed bank bit steers addresses 5h-8h
// - nibble moves 4 bits, byte 8 per clock
// - edge controls sampled on transmit clock ticks
// - output clock is tx clock gated by enable
`timescale 1ns/1ns
`default_nettype none
module bmec_ctrl #(
  parameter int FIFO_DEPTH = 32
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // host parallel port
  input wire logic [3:0] addr_in,
  input wire logic cs_n_in,
  input wire logic rd_n_in,
  input wire logic wr_n_in,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe_out,
  // pattern words from the generator
  input wire logic [7:0] pat_data_in,
  input wire logic pat_valid_in,
  output logic pat_ready_out,
  input wire logic zero_suppress_pattern_in,
  // transmit link
  input wire logic tx_clock_in,
  input wire logic tx_clock_gate_in,
  output logic [7:0] tx_data_out,
  output logic gapped_tx_clock_out,
  // receive link
  input wire logic rx_clock_in,
  input wire logic [7:0] rx_data_in,
  output logic [7:0] rx_check_data_out,
  output logic rx_check_valid_out,
  // controls to the rest of the engine
  output logic [1:0] width_sel_out,
  output logic [8:0] pat_end_addr_out,
  output logic fsm_mem_own_out,
  output logic host_mem_write_out,
  output logic host_mem_read_out,
  output logic count_bank_sel_out,
  output logic seed_bank_sel_out
);
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic [3:0] addr;
    logic [7:0] data;
    logic txc;
    logic txg;
    logic rxc;
    logic [7:0] rxd;
  } bmec_pins_t;
  typedef struct packed {
    bmec_pins_t sy1;
    bmec_pins_t sy2;
    logic [7:0] cr2;
    logic [7:0] cr3;
    logic [7:0] cr4;
    logic wr_prev;
    logic [7:0] rd_data;
    logic rd_oe;
    logic txc_prev;
    logic rxc_prev;
    logic trig_prev;
    logic sbe_pend;
    logic [23:0] rate_acc;
    logic [7:0] tx_data;
    logic [7:0] rx_data;
    logic rx_valid;
    logic clk_out;
  } bmec_ctrl_state_t;
  // strobes rest high so leaving reset cannot look like a host access
  localparam bmec_pins_t PINS_IDLE = '{cs_n: '1, rd_n: '1, wr_n: '1, default: '0};
  localparam bmec_ctrl_state_t ST_RESET = '{sy1: PINS_IDLE, sy2: PINS_IDLE, default: '0};

  function automatic logic [7:0] width_mask(input logic [1:0] w);
    unique case (w)
      bmec_pkg::BMEC_W_BIT: width_mask = bmec_pkg::MASK_BIT;
      bmec_pkg::BMEC_W_NIBBLE: width_mask = bmec_pkg::MASK_NIBBLE;
      bmec_pkg::BMEC_W_BYTE: width_mask = bmec_pkg::MASK_BYTE;
      bmec_pkg::BMEC_W_INVALID: width_mask = '0;
    endcase
  endfunction

  function automatic logic [3:0] width_bits(input logic [1:0] w);
    unique case (w)
      bmec_pkg::BMEC_W_BIT: width_bits = bmec_pkg::BITS_BIT;
      bmec_pkg::BMEC_W_NIBBLE: width_bits = bmec_pkg::BITS_NIBBLE;
      bmec_pkg::BMEC_W_BYTE: width_bits = bmec_pkg::BITS_BYTE;
      bmec_pkg::BMEC_W_INVALID: width_bits = '0;
    endcase
  endfunction

  // bits between inserted errors; wide paths cannot hit ten exactly, nor byte paths a hundred
  function automatic logic [23:0] rate_period(input logic [2:0] r, input logic [1:0] w);
    rate_period = '0;
    unique case (r)
      3'h1: rate_period = (w == bmec_pkg::BMEC_W_BIT) ? bmec_pkg::PER_E1 :
                          bmec_pkg::PER_OCT1;
      3'h2: rate_period = (w == bmec_pkg::BMEC_W_BYTE) ? bmec_pkg::PER_OCT2 :
                          bmec_pkg::PER_E2;
      3'h3: rate_period = bmec_pkg::PER_E3;
      3'h4: rate_period = bmec_pkg::PER_E4;
      3'h5: rate_period = bmec_pkg::PER_E5;
      3'h6: rate_period = bmec_pkg::PER_E6;
      3'h7: rate_period = bmec_pkg::PER_E7;
      3'h0: rate_period = '0;
    endcase
  endfunction

  bmec_ctrl_state_t st_r, st_nxt;
  bmec_stream_if #(.W(8)) in_if ();
  bmec_stream_if #(.W(8)) out_if ();

  bmec_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .wr_if(in_if),
    .rd_if(out_if)
  );

  logic [1:0] width;
  logic [2:0] rate;
  logic [7:0] mask;
  logic tx_tick, rx_tick, host_wr, host_rd, sbe_edge, zs, inj_single, rate_err;
  logic [24:0] acc_sum;
  logic [23:0] period;
  logic [7:0] word;

  assign in_if.valid = pat_valid_in;
  assign in_if.data = pat_data_in;
  assign pat_ready_out = in_if.ready;
  assign width = st_r.cr2[bmec_pkg::WIDTH_SEL_HI:bmec_pkg::WIDTH_SEL_LO];
  assign rate = st_r.cr2[bmec_pkg::ERR_RATE_SEL2:bmec_pkg::ERR_RATE_SEL0];
  assign mask = width_mask(width);
  assign period = rate_period(rate, width);
  assign zs = zero_suppress_pattern_in;
  // ticks only on sampled clock rising edges; no edge means no trigger detection
  assign tx_tick = st_r.sy2.txc && !st_r.txc_prev && st_r.sy2.txg &&
                   (width != bmec_pkg::BMEC_W_INVALID);
  assign rx_tick = st_r.sy2.rxc && !st_r.rxc_prev &&
                   (width != bmec_pkg::BMEC_W_INVALID);
  assign sbe_edge = st_r.cr2[bmec_pkg::SINGLE_ERROR_TRIGGER] && !st_r.trig_prev;
  assign inj_single = tx_tick && ((sbe_edge && !zs) || st_r.sbe_pend);
  assign acc_sum = {1'b0, st_r.rate_acc} + {21'h000000, width_bits(width)};
  assign rate_err = tx_tick && (rate != bmec_pkg::RATE_NONE) &&
                    (acc_sum >= {1'b0, period});
  assign out_if.ready = tx_tick;
  assign host_wr = !st_r.sy2.cs_n && !st_r.sy2.wr_n;
  assign host_rd = !st_r.sy2.cs_n && !st_r.sy2.rd_n;

  always_comb begin
    st_nxt = st_r;
    st_nxt.sy1 = {cs_n_in, rd_n_in, wr_n_in, addr_in, data_in, tx_clock_in,
                  tx_clock_gate_in, rx_clock_in, rx_data_in};
    st_nxt.sy2 = st_r.sy1;
    st_nxt.txc_prev = st_r.sy2.txc;
    st_nxt.rxc_prev = st_r.sy2.rxc;
    st_nxt.wr_prev = host_wr;
    word = out_if.valid ? out_if.data : '0;
    // one write per strobe, taken on its leading edge
    if (host_wr && !st_r.wr_prev) begin
      unique case (st_r.sy2.addr)
        bmec_pkg::ADDR_WIDTH_INV_ERR: st_nxt.cr2 = st_r.sy2.data;
        bmec_pkg::ADDR_END_ADDR_LOW: st_nxt.cr3 = st_r.sy2.data;
        bmec_pkg::ADDR_ACCESS_BANK_CLK: st_nxt.cr4 = st_r.sy2.data;
        default: ;
      endcase
    end
    st_nxt.rd_oe = 1'b0;
    if (host_rd) begin
      st_nxt.rd_oe = 1'b1;
      unique case (st_r.sy2.addr)
        bmec_pkg::ADDR_WIDTH_INV_ERR: st_nxt.rd_data = st_r.cr2;
        bmec_pkg::ADDR_END_ADDR_LOW: st_nxt.rd_data = st_r.cr3;
        bmec_pkg::ADDR_ACCESS_BANK_CLK: st_nxt.rd_data = st_r.cr4;
        default: st_nxt.rd_oe = 1'b0;
      endcase
    end
    if (tx_tick) begin
      st_nxt.trig_prev = st_r.cr2[bmec_pkg::SINGLE_ERROR_TRIGGER];
      // under zero suppression the error waits one tick, set wins over consume
      st_nxt.sbe_pend = sbe_edge && zs;
      if (rate == bmec_pkg::RATE_NONE) begin
        st_nxt.rate_acc = '0;
      end else if (rate_err) begin
        st_nxt.rate_acc = 24'(acc_sum - {1'b0, period});
      end else begin
        st_nxt.rate_acc = acc_sum[23:0];
      end
      if (st_r.cr2[bmec_pkg::TX_DATA_FLIP]) begin
        word = ~word;
      end
      word[0] = word[0] ^ inj_single ^ rate_err;
      st_nxt.tx_data = word & mask;
    end
    st_nxt.rx_valid = rx_tick;
    if (rx_tick) begin
      st_nxt.rx_data = (st_r.sy2.rxd ^ {8{st_r.cr2[bmec_pkg::RX_DATA_FLIP]}}) & mask;
    end
    st_nxt.clk_out = (st_r.sy2.txc && st_r.sy2.txg) ^
                     st_r.cr4[bmec_pkg::TXCLK_OUT_POLARITY];
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      st_r <= ST_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign data_out = st_r.rd_data;
  assign data_oe_out = st_r.rd_oe;
  assign tx_data_out = st_r.tx_data;
  assign gapped_tx_clock_out = st_r.clk_out;
  assign rx_check_data_out = st_r.rx_data;
  assign rx_check_valid_out = st_r.rx_valid;
  assign width_sel_out = width;
  assign pat_end_addr_out = {st_r.cr4[bmec_pkg::PAT_END_BIT_TOP], st_r.cr3};
  assign fsm_mem_own_out = !st_r.cr4[bmec_pkg::MEM_HOST_OWN];
  assign host_mem_write_out = st_r.cr4[bmec_pkg::MEM_HOST_OWN] &&
                              !st_r.cr4[bmec_pkg::MEM_DIR_READ];
  assign host_mem_read_out = st_r.cr4[bmec_pkg::MEM_HOST_OWN] &&
                             st_r.cr4[bmec_pkg::MEM_DIR_READ];
  assign count_bank_sel_out = st_r.cr4[bmec_pkg::COUNT_BANK];
  assign seed_bank_sel_out = st_r.cr4[bmec_pkg::SEED_BANK];

  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);

  a_invalid_width_idle: assert property (
    (width == bmec_pkg::BMEC_W_INVALID) |-> (!tx_tick && !rx_tick))
    else $error("tick while width code invalid");
  a_tx_flip_word: assert property (
    (tx_tick && !inj_single && !rate_err && st_r.cr2[bmec_pkg::TX_DATA_FLIP])
      |=> tx_data_out == $past(~(out_if.data & {8{out_if.valid}}) & mask))
    else $error("outbound word not inverted");
  a_rx_flip_word: assert property (
    rx_tick |=> rx_check_valid_out &&
      rx_check_data_out == $past((st_r.sy2.rxd ^ {8{st_r.cr2[bmec_pkg::RX_DATA_FLIP]}}) & mask))
    else $error("inbound word wrong");
  a_single_once: assert property (
    (inj_single && !st_r.sbe_pend) |=> !sbe_edge)
    else $error("second single error without new edge");
  a_zs_delay_one: assert property (
    (tx_tick && sbe_edge && zs) |-> !inj_single ##1 st_r.sbe_pend)
    else $error("zero suppressed error not delayed");
  a_zs_pend_used: assert property (
    (tx_tick && st_r.sbe_pend) |-> inj_single ##1 !st_r.sbe_pend)
    else $error("delayed single error not inserted");
  a_rate_none: assert property (
    (rate == bmec_pkg::RATE_NONE) |-> !rate_err)
    else $error("error inserted with rate none");
  a_rate_byte_oct: assert property (
    (rate == bmec_pkg::RATE_E2 && width == bmec_pkg::BMEC_W_BYTE) |-> period == bmec_pkg::PER_OCT2)
    else $error("byte rate two period wrong");
  a_rate_wide_oct: assert property (
    (rate == bmec_pkg::RATE_E1 && width != bmec_pkg::BMEC_W_BIT) |-> period == bmec_pkg::PER_OCT1)
    else $error("wide rate one period wrong");
  a_mem_owner_dir: assert property (
    (fsm_mem_own_out |-> !host_mem_write_out && !host_mem_read_out) and
    (!fsm_mem_own_out |-> (host_mem_write_out ^ host_mem_read_out)))
    else $error("memory owner or direction clash");
  a_clk_polarity: assert property (
    ##2 gapped_tx_clock_out == ($past(st_r.sy2.txc && st_r.sy2.txg) ^
      $past(st_r.cr4[bmec_pkg::TXCLK_OUT_POLARITY])))
    else $error("gapped clock polarity wrong");
  a_host_write_reg: assert property (
    (host_wr && !st_r.wr_prev && st_r.sy2.addr == bmec_pkg::ADDR_END_ADDR_LOW)
      |=> pat_end_addr_out[7:0] == $past(st_r.sy2.data))
    else $error("end address write lost");
  c_single_error: cover property (inj_single);
  c_rate_error: cover property (rate_err && width == bmec_pkg::BMEC_W_BYTE);
  c_host_read: cover property (data_oe_out);
  c_zs_delay: cover property (st_r.sbe_pend && tx_tick);
endmodule // bmec_ctrl
`default_nettype wire

// ===== bench/bmec_link_model.sv
/*
  far end of the transmit and receive links: makes both link clocks and
  the receive data. assumes the bench raises run_in only while a frame of
  traffic is wanted; clocks stand still otherwise.
*/
`timescale 1ns/1ns
`default_nettype none
module bmec_link_model (
  // control from the bench
  input wire logic run_in,
  input wire logic [7:0] rx_word_in,
  // link pins
  output logic tx_clock_out,
  output logic tx_gate_out,
  output logic rx_clock_out,
  output logic [7:0] rx_data_out
);
  assign tx_gate_out = run_in;
  // a cut frame finishes its high half, so both clocks rest low between frames
  initial begin
    tx_clock_out = 1'b0;
    forever #24 if (run_in || tx_clock_out) tx_clock_out = ~tx_clock_out;
  end
  // rx clock is offset so the two links never line up
  initial begin
    rx_clock_out = 1'b0;
    rx_data_out = 8'h00;
    #7;
    forever begin
      #24;
      if (run_in || rx_clock_out) rx_clock_out = ~rx_clock_out;
      // idle data keeps moving so a stale value is never mistaken for live data
      if (!rx_clock_out) rx_data_out = run_in ? rx_word_in : ~rx_data_out;
    end
  end
endmodule // bmec_link_model
`default_nettype wire

// ===== bench/tb_top.sv
/*
  self-checking bench for the pattern engine control block.
  assumes the link model above drives the link pins; host strobes, pattern
  words and reset are driven here on the core clock.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic [3:0] addr_in = 4'h0;
  logic cs_n_in = 1'b1;
  logic rd_n_in = 1'b1;
  logic wr_n_in = 1'b1;
  logic [7:0] data_in = 8'h00;
  logic [7:0] pat_data_in = 8'h00;
  logic pat_valid_in = 1'b0;
  logic run = 1'b0;
  logic [7:0] rx_word = 8'h00;
  logic [7:0] data_out, tx_data_out, rx_check_data_out, last_tx;
  logic data_oe_out, pat_ready_out, gapped_tx_clock_out, rx_check_valid_out, gap_d;
  logic fsm_mem_own_out, host_mem_write_out, host_mem_read_out;
  logic count_bank_sel_out, seed_bank_sel_out, mon_on = 1'b0;
  logic [1:0] width_sel_out;
  logic [8:0] pat_end_addr_out;
  logic tx_clock, tx_gate, rx_clock;
  logic zs = 1'b0;
  logic [2:0] mem_acc;
  logic [7:0] rx_data;
  logic [7:0] q[$];
  int fails = 0, checks_done = 0, cyc = 0, ticks = 0, ones = 0;

  always #2 clock_in = ~clock_in;
  assign mem_acc = {fsm_mem_own_out, host_mem_write_out, host_mem_read_out};

  bmec_link_model link_far (.run_in(run), .rx_word_in(rx_word), .tx_clock_out(tx_clock),
    .tx_gate_out(tx_gate), .rx_clock_out(rx_clock), .rx_data_out(rx_data));

  bmec_ctrl #(.FIFO_DEPTH(32)) dut (.clock_in(clock_in), .rst_in(rst_in), .addr_in(addr_in),
    .cs_n_in(cs_n_in), .rd_n_in(rd_n_in), .wr_n_in(wr_n_in), .data_in(data_in),
    .data_out(data_out), .data_oe_out(data_oe_out), .pat_data_in(pat_data_in),
    .pat_valid_in(pat_valid_in), .pat_ready_out(pat_ready_out),
    .zero_suppress_pattern_in(zs), .tx_clock_in(tx_clock), .tx_clock_gate_in(tx_gate),
    .tx_data_out(tx_data_out), .gapped_tx_clock_out(gapped_tx_clock_out),
    .rx_clock_in(rx_clock), .rx_data_in(rx_data), .rx_check_data_out(rx_check_data_out),
    .rx_check_valid_out(rx_check_valid_out), .width_sel_out(width_sel_out),
    .pat_end_addr_out(pat_end_addr_out), .fsm_mem_own_out(fsm_mem_own_out),
    .host_mem_write_out(host_mem_write_out), .host_mem_read_out(host_mem_read_out),
    .count_bank_sel_out(count_bank_sel_out), .seed_bank_sel_out(seed_bank_sel_out));

  task automatic end_of_test();
    if (fails == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // sampled on the falling edge so registered outputs have settled
  always @(negedge clock_in) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      end_of_test();
    end
    if (mon_on) begin
      if (tx_data_out !== last_tx) q.push_back(tx_data_out);
      if (gapped_tx_clock_out && !gap_d) ticks++;
      if (tx_data_out[0] && !last_tx[0]) ones++;
    end
    gap_d = gapped_tx_clock_out;
    last_tx = tx_data_out;
  end

  task automatic chk(input string nm, input logic [8:0] exp, input logic [8:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock_in);
  endtask

  // address and data settle before the strobes, which stay low past the sync delay
  task automatic host_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock_in);
    addr_in <= a;
    data_in <= d;
    wait_cyc(3);
    cs_n_in <= 1'b0;
    wr_n_in <= 1'b0;
    wait_cyc(5);
    cs_n_in <= 1'b1;
    wr_n_in <= 1'b1;
    wait_cyc(4);
  endtask

  task automatic host_rd(input logic [3:0] a, input logic [8:0] exp, input logic oe);
    @(posedge clock_in);
    addr_in <= a;
    wait_cyc(3);
    cs_n_in <= 1'b0;
    rd_n_in <= 1'b0;
    wait_cyc(5);
    @(negedge clock_in);
    chk("read enable", {8'h00, oe}, {8'h00, data_oe_out});
    if (oe) chk("read data", exp, {1'b0, data_out});
    @(posedge clock_in);
    cs_n_in <= 1'b1;
    rd_n_in <= 1'b1;
    wait_cyc(4);
  endtask

  task automatic link(input int n);
    @(posedge clock_in);
    run <= 1'b1;
    repeat (n) @(posedge tx_clock);
    @(posedge clock_in);
    run <= 1'b0;
    wait_cyc(8);
  endtask

  task automatic mon_start();
    q.delete();
    ticks = 0;
    ones = 0;
    mon_on = 1'b1;
  endtask

  task automatic t_regs();
    chk("reset own", 9'h001, {8'h00, fsm_mem_own_out});
    host_rd(4'h1, 9'h000, 1'b1);
    host_rd(4'h3, 9'h000, 1'b1);
    host_wr(4'h2, 8'ha5);
    host_wr(4'h3, 8'h19);
    host_wr(4'h1, 8'h80);
    host_rd(4'h1, 9'h080, 1'b1);
    host_rd(4'h2, 9'h0a5, 1'b1);
    host_rd(4'h3, 9'h019, 1'b1);
    host_rd(4'h4, 9'h000, 1'b0);
    chk("width", 9'h002, {7'h00, width_sel_out});
    chk("end addr", 9'h1a5, pat_end_addr_out);
    chk("mem access", 9'h001, {6'h00, mem_acc});
    host_wr(4'h3, 8'h0e);
    chk("end addr", 9'h0a5, pat_end_addr_out);
    chk("mem access", 9'h002, {6'h00, mem_acc});
    chk("banks", 9'h003, {7'h00, count_bank_sel_out, seed_bank_sel_out});
    host_wr(4'h3, 8'h00);
    chk("mem access", 9'h004, {6'h00, mem_acc});
    chk("banks", 9'h000, {7'h00, count_bank_sel_out, seed_bank_sel_out});
  endtask

  // fill until the buffer refuses, then drain it through the link in byte width
  task automatic t_fill();
    int n;
    n = 0;
    @(posedge clock_in);
    pat_valid_in <= 1'b1;
    pat_data_in <= 8'h01;
    for (int i = 0; i < 60; i++) begin
      @(negedge clock_in);
      if (pat_ready_out !== 1'b1) break;
      n++;
      @(posedge clock_in);
      pat_data_in <= 8'(n + 1);
    end
    @(posedge clock_in);
    pat_valid_in <= 1'b0;
    chk("words held", 9'h021, 9'(n));
    mon_start();
    link(40);
    mon_on = 1'b0;
    chk("drain count", 9'h022, 9'(q.size()));
    chk("first word", 9'h001, {1'b0, q[0]});
    chk("last word", 9'h021, {1'b0, q[32]});
    chk("room again", 9'h001, {8'h00, pat_ready_out});
  endtask

  task automatic t_flip();
    logic [7:0] cfg[3];
    logic [7:0] exp[3];
    cfg = '{8'h20, 8'h60, 8'ha0};
    exp = '{8'h01, 8'h0f, 8'hff};
    for (int i = 0; i < 3; i++) begin
      host_wr(4'h1, cfg[i]);
      link(3);
      chk("flipped idle", {1'b0, exp[i]}, {1'b0, tx_data_out});
    end
  endtask

  task automatic push_words(input logic [7:0] a, input logic [7:0] b);
    @(posedge clock_in);
    pat_valid_in <= 1'b1;
    pat_data_in <= a;
    @(posedge clock_in);
    pat_data_in <= b;
    @(posedge clock_in);
    pat_valid_in <= 1'b0;
  endtask

  // two buffered words show on which tick the single error lands
  task automatic t_single();
    for (int i = 0; i < 2; i++) begin
      zs <= 1'(i);
      host_wr(4'h1, 8'h80);
      link(2);
      push_words(8'h10, 8'h20);
      mon_start();
      host_wr(4'h1, 8'h88);
      link(10);
      mon_on = 1'b0;
      chk("single error changes", 9'h003, 9'(q.size()));
      chk("single error first", (i == 0) ? 9'h011 : 9'h010, {1'b0, q[0]});
      chk("single error second", (i == 0) ? 9'h020 : 9'h021, {1'b0, q[1]});
    end
    host_wr(4'h1, 8'h80);
    zs <= 1'b0;
  endtask

  // per is the expected number of link ticks between inserted errors
  task automatic rate_case(input logic [7:0] cfg, input int per);
    host_wr(4'h1, cfg);
    mon_start();
    link(64);
    mon_on = 1'b0;
    checks_done++;
    if (ones * per > ticks + per || ones * per + per < ticks) begin
      fails++;
      $display("FAIL error count expected %0d seen %0d", ticks / per, ones);
    end
  endtask

  task automatic t_rx();
    int n;
    n = 0;
    host_wr(4'h1, 8'h50);
    @(posedge clock_in);
    rx_word <= 8'h5a;
    run <= 1'b1;
    wait_cyc(60);
    do begin
      @(negedge clock_in);
      n++;
    end while (rx_check_valid_out !== 1'b1 && n < 100);
    chk("rx valid", 9'h001, {8'h00, rx_check_valid_out});
    chk("rx data", 9'h005, {1'b0, rx_check_data_out});
    @(posedge clock_in);
    run <= 1'b0;
    wait_cyc(8);
  endtask

  task automatic t_pol_idle();
    host_wr(4'h3, 8'h20);
    wait_cyc(8);
    chk("clock out inverted", 9'h001, {8'h00, gapped_tx_clock_out});
    host_wr(4'h3, 8'h00);
    wait_cyc(8);
    chk("clock out normal", 9'h000, {8'h00, gapped_tx_clock_out});
    host_wr(4'h1, 8'he0);
    mon_start();
    link(8);
    mon_on = 1'b0;
    chk("invalid width changes", 9'h000, 9'(q.size()));
  endtask

  initial begin
    wait_cyc(4);
    rst_in <= 1'b0;
    wait_cyc(2);
    t_regs();
    t_fill();
    t_flip();
    t_single();
    rate_case(8'h41, 2);
    rate_case(8'h82, 8);
    rate_case(8'h01, 10);
    t_rx();
    t_pol_idle();
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
